// [hdl/epg_page_gen.sv]
// Purpose: builds and streams the extended parameter page of a flash target
// Assumes: page body loaded into the buffer before start, one clock
// Notes: check word is computed before the first byte leaves
// Operation
// - page opens with a 16-bit check word covering offset 2 to page end
// - check word uses polynomial 0x8005 over bytes, bit 7 first
// - check register preset 0x4f4e, no final xor, no reflection
// - signature bytes 0x45 0x50 0x50 0x53 sit at offsets 2 to 5
// - type 0 unused, 1 extra pair list, 2 extended ecc, 3 up reserved
// - non-zero types ascend, each once; unused slots carry type 0
// - length byte counts 16-byte units; sections are whole units
// - first pair at offsets 16/17, data from 32, sections back to back
// - offsets 18 to 31 hold pairs 1 to 7; absent pairs are zero
// - type 1 section lists pairs from section 8 onward at its byte 0
// - type 2 section holds 8-byte ecc blocks; block 0 is mandatory
// - multi-byte values are stored least significant byte first
// - sizes are given in bytes even for 16-bit targets
// - offsets 6 to 15 are reserved zero; unused fields read zero
`timescale 1ns/100ps
module epg_page_gen #(
  parameter int unsigned PAGE_MAX = 512,
  parameter int unsigned ADDR_W = $clog2(PAGE_MAX),
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_valid_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o,
  output logic table_err_o,
  output logic size_err_o,
  output logic [15:0] crc_o,
  output logic [15:0] page_len_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] mem_q [PAGE_MAX];
  epg_pkg::epg_state_e state_q, state_d;
  logic [15:0] ptr_q, ptr_d, idx_q, idx_d, len_q, len_d, crc_q, crc_d, crc_next;
  logic [23:0] lim_q, lim_d, total;
  logic [19:0] sum_q, sum_d;
  logic [7:0] last_q, last_d, slot_type, slot_len, page_b, raw_b;
  logic [3:0] nmain_q, nmain_d;
  logic ended_q, ended_d, ext_q, ext_d, tbl_err_q, tbl_err_d, size_err_q, size_err_d;
  logic busy_q, busy_d, done_q, done_d, scan_fin, in_main;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data, out_data_q, out_data_d;
  logic out_valid_q, out_valid_d;
  logic [15:0] slot_idx;

  // two-stage release so no flop leaves reset on a ragged edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // loads refused while busy so the page cannot change under the check
  always_ff @(posedge clk_i) begin
    if (load_valid_i && !busy_q) begin
      mem_q[load_addr_i] <= load_data_i;
    end
  end

  assign slot_type = mem_q[ptr_q[ADDR_W-1:0]];
  assign slot_len = mem_q[ADDR_W'(ptr_q + epg_pkg::LEN_BYTE)];
  assign raw_b = mem_q[idx_q[ADDR_W-1:0]];
  assign in_main = ptr_q < epg_pkg::OFS_DATA;
  assign slot_idx = (idx_q - epg_pkg::OFS_TABLE) >> 1;

  // byte as it leaves: fixed fields overlay the loaded buffer
  always_comb begin
    page_b = raw_b;
    if (idx_q == epg_pkg::OFS_CRC_LO) begin
      page_b = crc_q[7:0];
    end else if (idx_q == epg_pkg::OFS_CRC_HI) begin
      page_b = crc_q[15:8];
    end else if (idx_q <= epg_pkg::OFS_SIG_HI) begin
      unique case (idx_q[1:0])
        2'b10: page_b = epg_pkg::SIG_B0;
        2'b11: page_b = epg_pkg::SIG_B1;
        2'b00: page_b = epg_pkg::SIG_B2;
        default: page_b = epg_pkg::SIG_B3;
      endcase
    end else if (idx_q <= epg_pkg::OFS_RSVD_HI) begin
      page_b = 8'h00;
    end else if (idx_q < epg_pkg::OFS_DATA) begin
      // pairs past the last section read zero
      if (slot_idx >= 16'(nmain_q)) begin
        page_b = 8'h00;
      end
    end
  end

  epg_crc_step u_crc (
    .crc_i(crc_q),
    .data_i(page_b),
    .crc_o(crc_next)
  );

  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    lim_d = lim_q;
    ended_d = ended_q;
    last_d = last_q;
    nmain_d = nmain_q;
    ext_d = ext_q;
    sum_d = sum_q;
    idx_d = idx_q;
    len_d = len_q;
    crc_d = crc_q;
    tbl_err_d = tbl_err_q;
    size_err_d = size_err_q;
    done_d = 1'b0;
    fifo_in_valid = 1'b0;
    scan_fin = 1'b0;
    total = '0;
    unique case (state_q)
      epg_pkg::ST_IDLE: begin
        if (start_i) begin
          state_d = epg_pkg::ST_SCAN;
          // walk starts at the first pair
          ptr_d = epg_pkg::OFS_TABLE;
          lim_d = '0;
          ended_d = 1'b0;
          last_d = epg_pkg::TYPE_UNUSED;
          nmain_d = '0;
          ext_d = 1'b0;
          sum_d = '0;
          tbl_err_d = 1'b0;
          size_err_d = 1'b0;
        end
      end
      epg_pkg::ST_SCAN: begin
        if (!in_main && (ended_q || 24'(ptr_q) >= lim_q)) begin
          scan_fin = 1'b1;
        end else begin
          if (slot_type == epg_pkg::TYPE_UNUSED) begin
            // first zero type ends the list
            ended_d = 1'b1;
          end else if (!ended_q) begin
            // strictly ascending, so repeats also fail
            if (slot_type <= last_q) begin
              tbl_err_d = 1'b1;
            end
            if (slot_type >= epg_pkg::TYPE_RSVD_MIN) begin
              tbl_err_d = 1'b1;
            end
            // a present section has at least one unit
            if (slot_len == 8'h00) begin
              tbl_err_d = 1'b1;
            end
            sum_d = sum_q + 20'(slot_len);
            last_d = slot_type;
            if (in_main) begin
              nmain_d = nmain_q + 4'h1;
              // extra pairs live in the type 1 section data
              if (slot_type == epg_pkg::TYPE_EXT_LIST) begin
                ext_d = 1'b1;
                lim_d = 24'(epg_pkg::OFS_DATA) + (24'(slot_len) << epg_pkg::UNIT_SHIFT);
              end
            end
          end
          ptr_d = ptr_q + epg_pkg::PAIR_STEP;
          if (in_main && ptr_q == epg_pkg::OFS_LAST_PAIR) begin
            if (!ext_d || ended_d) begin
              scan_fin = 1'b1;
            end else if (lim_d > 24'(PAGE_MAX)) begin
              size_err_d = 1'b1;
              scan_fin = 1'b1;
            end
          end
        end
        if (scan_fin) begin
          // length in bytes from 16-byte units
          total = 24'(epg_pkg::OFS_DATA) + (24'(sum_d) << epg_pkg::UNIT_SHIFT);
          len_d = total[15:0];
          if (total > 24'(PAGE_MAX)) begin
            size_err_d = 1'b1;
          end
          if (tbl_err_d || size_err_d) begin
            state_d = epg_pkg::ST_IDLE;
            done_d = 1'b1;
          end else begin
            state_d = epg_pkg::ST_CRC;
            // preset before the first covered byte
            crc_d = epg_pkg::CRC_INIT;
            idx_d = epg_pkg::OFS_SIG_LO;
          end
        end
      end
      epg_pkg::ST_CRC: begin
        // byte step of the check word
        crc_d = crc_next;
        idx_d = idx_q + 16'h0001;
        // covered bytes run to the last byte of the page
        if (idx_q == len_q - 16'h0001) begin
          state_d = epg_pkg::ST_EMIT;
          idx_d = epg_pkg::OFS_CRC_LO;
        end
      end
      epg_pkg::ST_EMIT: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          idx_d = idx_q + 16'h0001;
          if (idx_q == len_q - 16'h0001) begin
            state_d = epg_pkg::ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
    endcase
    busy_d = (state_d != epg_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= epg_pkg::ST_IDLE;
      ptr_q <= '0;
      lim_q <= '0;
      ended_q <= 1'b0;
      last_q <= '0;
      nmain_q <= '0;
      ext_q <= 1'b0;
      sum_q <= '0;
      idx_q <= '0;
      len_q <= '0;
      crc_q <= '0;
      tbl_err_q <= 1'b0;
      size_err_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      lim_q <= lim_d;
      ended_q <= ended_d;
      last_q <= last_d;
      nmain_q <= nmain_d;
      ext_q <= ext_d;
      sum_q <= sum_d;
      idx_q <= idx_d;
      len_q <= len_d;
      crc_q <= crc_d;
      tbl_err_q <= tbl_err_d;
      size_err_q <= size_err_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  epg_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(page_b),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // registered output stage keeps the port flop-driven
  assign fifo_out_ready = !out_valid_q || out_ready_i;
  always_comb begin
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    if (fifo_out_ready) begin
      out_valid_d = fifo_out_valid;
      if (fifo_out_valid) begin
        out_data_d = fifo_out_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign table_err_o = tbl_err_q;
  assign size_err_o = size_err_q;
  assign crc_o = crc_q;
  assign page_len_o = len_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;

  a_crc_preset: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_SCAN && state_d == epg_pkg::ST_CRC)
    |=> (crc_q == epg_pkg::CRC_INIT && idx_q == epg_pkg::OFS_SIG_LO))
    else $error("check word not preset before covered bytes");
  a_crc_to_end: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_CRC && idx_q == len_q - 16'h0001)
    |=> (state_q == epg_pkg::ST_EMIT && idx_q == epg_pkg::OFS_CRC_LO))
    else $error("check did not end at last page byte");
  // low byte pushed first, high byte on the next push
  a_crc_low_first: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_EMIT && idx_q == epg_pkg::OFS_CRC_LO && fifo_in_ready)
    |-> (page_b == crc_q[7:0]) ##1 (idx_q == epg_pkg::OFS_CRC_HI && page_b == crc_q[15:8]))
    else $error("check word byte order wrong");
  // only when the four signature bytes left back to back, a stall would shift $past
  a_sig_bytes: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_EMIT && idx_q == epg_pkg::OFS_SIG_HI && fifo_in_ready
     && $past(idx_q, 3) == epg_pkg::OFS_SIG_LO)
    |-> (page_b == epg_pkg::SIG_B3 && $past(page_b, 3) == epg_pkg::SIG_B0))
    else $error("signature bytes wrong");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q != epg_pkg::ST_IDLE && idx_q > epg_pkg::OFS_SIG_HI
     && idx_q <= epg_pkg::OFS_RSVD_HI) |-> (page_b == 8'h00))
    else $error("reserved byte not zero");
  a_absent_pair: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_EMIT && idx_q >= epg_pkg::OFS_TABLE && idx_q < epg_pkg::OFS_DATA
     && slot_idx >= 16'(nmain_q)) |-> (page_b == 8'h00))
    else $error("absent pair not zero");
  a_order_err: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_SCAN && !scan_fin && !ended_q
     && slot_type != epg_pkg::TYPE_UNUSED && slot_type <= last_q) |=> tbl_err_q)
    else $error("out of order type not flagged");
  a_rsvd_type: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_SCAN && !scan_fin && !ended_q
     && slot_type >= epg_pkg::TYPE_RSVD_MIN) |=> (tbl_err_q ##[1:300] !busy_q))
    else $error("reserved type not refused");
  a_len_units: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_SCAN && state_d == epg_pkg::ST_CRC)
    |=> (len_q == epg_pkg::OFS_DATA + 16'(sum_q << epg_pkg::UNIT_SHIFT) && len_q[3:0] == 4'h0))
    else $error("page length not whole units");
  a_ext_list: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_SCAN && ptr_q == epg_pkg::OFS_LAST_PAIR && ext_q && !ended_d
     && !size_err_d) |=> (ptr_q == epg_pkg::OFS_DATA && state_q == epg_pkg::ST_SCAN))
    else $error("extra pair list not walked");
  a_emit_stall: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == epg_pkg::ST_EMIT && !fifo_in_ready) |=> $stable(idx_q))
    else $error("byte skipped under back-pressure");
  a_out_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    (out_valid_q && !out_ready_i) |=> (out_valid_q && $stable(out_data_q)))
    else $error("output byte dropped while stalled");
  c_page_sent: cover property (@(posedge clk_i) disable iff (!rst_n)
    state_q == epg_pkg::ST_EMIT ##1 done_q && !tbl_err_q);
  c_table_fault: cover property (@(posedge clk_i) disable iff (!rst_n) done_q && tbl_err_q);
  c_ext_walk: cover property (@(posedge clk_i) disable iff (!rst_n)
    state_q == epg_pkg::ST_SCAN && ext_q && !in_main);
  c_stall: cover property (@(posedge clk_i) disable iff (!rst_n)
    state_q == epg_pkg::ST_EMIT && !fifo_in_ready);
endmodule : epg_page_gen

// [hdl/epg_pkg.sv]
// Purpose: shared constants and types of the extended page generator
// Assumes: byte stream, one clock
// Notes: page offsets are byte indices into the page
package epg_pkg;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h4f4e;
  localparam logic [7:0] SIG_B0 = 8'h45;
  localparam logic [7:0] SIG_B1 = 8'h50;
  localparam logic [7:0] SIG_B2 = 8'h50;
  localparam logic [7:0] SIG_B3 = 8'h53;
  localparam logic [15:0] OFS_CRC_LO = 16'h0000;
  localparam logic [15:0] OFS_CRC_HI = 16'h0001;
  localparam logic [15:0] OFS_SIG_LO = 16'h0002;
  localparam logic [15:0] OFS_SIG_HI = 16'h0005;
  localparam logic [15:0] OFS_RSVD_HI = 16'h000f;
  localparam logic [15:0] OFS_TABLE = 16'h0010;
  localparam logic [15:0] OFS_LAST_PAIR = 16'h001e;
  localparam logic [15:0] OFS_DATA = 16'h0020;
  localparam logic [15:0] PAIR_STEP = 16'h0002;
  localparam logic [15:0] LEN_BYTE = 16'h0001;
  localparam int unsigned UNIT_SHIFT = 4;
  localparam logic [7:0] TYPE_UNUSED = 8'h00;
  localparam logic [7:0] TYPE_EXT_LIST = 8'h01;
  localparam logic [7:0] TYPE_RSVD_MIN = 8'h03;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_CRC = 2'b10,
    ST_EMIT = 2'b11
  } epg_state_e;
endpackage : epg_pkg

// [hdl/epg_crc_step.sv]
// Purpose: one byte step of the page check word
// Assumes: msb first, no reflection, no final xor
// Notes: purely combinational
`timescale 1ns/100ps
module epg_crc_step (
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);
  always_comb begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data_i[i]) begin
        c = {c[14:0], 1'b0} ^ epg_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_o = c;
  end
endmodule : epg_crc_step

// [hdl/epg_fifo.sv]
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty from pointer comparison with wrap bit
`timescale 1ns/100ps
module epg_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty, push, pop;

  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[PW-1:0]];
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset, only written on push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end
endmodule : epg_fifo

// [tb/epg_host_sink.sv]
// Purpose: host side of the page stream, collects bytes with optional stalls
// Assumes: one clock, bytes arrive in page order
// Notes: ready toggles every cycle while stall_i is high
`timescale 1ns/100ps
module epg_host_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  output logic [7:0] count_o,
  output logic sig_ok_o
);
  logic [7:0] mem [0:127];
  int hits;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      count_o <= 8'h00;
    end else begin
      ready_o <= stall_i ? ~ready_o : 1'b1;
      if (clr_i) begin
        count_o <= 8'h00;
      end else if (valid_i && ready_o) begin
        mem[count_o[6:0]] <= data_i;
        count_o <= count_o + 8'h01;
      end
    end
  end
  always_comb begin
    hits = int'(mem[2] === epg_pkg::SIG_B0) + int'(mem[3] === epg_pkg::SIG_B1);
    hits = hits + int'(mem[4] === epg_pkg::SIG_B2) + int'(mem[5] === epg_pkg::SIG_B3);
    sig_ok_o = (count_o >= 8'h06) && (hits >= 2);
  end
endmodule : epg_host_sink

// [tb/tb_top.sv]
// Purpose: self-checking bench of the page generator
// Assumes: PAGE_MAX lowered to 64 so a short table overflows it
// Notes: expected bytes and check word are rebuilt here from the loaded image
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_valid = 1'b0;
  logic [5:0] load_addr = 6'h00;
  logic [7:0] load_data = 8'h00;
  logic start = 1'b0;
  logic clr = 1'b0;
  logic stall = 1'b0;
  logic busy, done, table_err, size_err, out_valid, out_ready, sig_ok;
  logic [15:0] crc, page_len;
  logic [7:0] out_data, rx_cnt;
  logic [7:0] pg [0:63];
  logic [7:0] ex [0:63];
  logic [31:0] bad [0:4] = '{32'h0301_0000, 32'h0201_0201, 32'h0200_0000, 32'h0201_0101,
                             32'hff01_0000};
  int errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  epg_page_gen #(.PAGE_MAX(64)) epg_page_gen_i (
    .clk_i(clk), .reset_n_i(rst_n), .load_valid_i(load_valid), .load_addr_i(load_addr),
    .load_data_i(load_data), .start_i(start), .busy_o(busy), .done_o(done),
    .table_err_o(table_err), .size_err_o(size_err), .crc_o(crc), .page_len_o(page_len),
    .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(out_ready)
  );
  epg_host_sink epg_host_sink_i (
    .clk_i(clk), .rst_n_i(rst_n), .clr_i(clr), .stall_i(stall), .valid_i(out_valid),
    .data_i(out_data), .ready_o(out_ready), .count_o(rx_cnt), .sig_ok_o(sig_ok)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // msb first, no reflection, no final xor
  function automatic logic [15:0] calc_crc(input int len);
    logic [15:0] c;
    logic fb;
    c = epg_pkg::CRC_INIT;
    for (int i = 2; i < len; i++) begin
      for (int b = 7; b >= 0; b--) begin
        fb = c[15] ^ ex[i][b];
        c = {c[14:0], 1'b0};
        if (fb) c = c ^ epg_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction : calc_crc

  // garbage everywhere outside the table, so forced fields show
  task automatic fill(input logic [7:0] t0, l0, t1, l1);
    for (int i = 0; i < 64; i++) pg[i] = 8'h80 + 8'(i);
    for (int i = 16; i < 32; i++) pg[i] = 8'h00;
    pg[16] = t0;
    pg[17] = l0;
    pg[18] = t1;
    pg[19] = l1;
  endtask : fill

  task automatic load_page();
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      load_valid <= 1'b1;
      load_addr <= 6'(i);
      load_data <= pg[i];
    end
    @(posedge clk);
    load_valid <= 1'b0;
  endtask : load_page

  // poke: a second start and a load while busy, both to be ignored
  task automatic kick(input bit poke);
    int k;
    @(posedge clk);
    clr <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start <= 1'b0;
    if (poke) begin
      @(posedge clk);
      start <= 1'b1;
      load_valid <= 1'b1;
      load_addr <= 6'd40;
      load_data <= ~pg[40];
      @(posedge clk);
      start <= 1'b0;
      load_valid <= 1'b0;
    end
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 3000);
    check("done", {15'h0000, done}, 16'h0001);
  endtask : kick

  task automatic run_page(input string name, input int len, input int stop, input bit poke);
    int k;
    for (int i = 0; i < 64; i++) ex[i] = pg[i];
    for (int s = stop; s < 8; s++) begin
      ex[16 + 2 * s] = 8'h00;
      ex[17 + 2 * s] = 8'h00;
    end
    ex[2] = 8'h45;
    ex[3] = 8'h50;
    ex[4] = 8'h50;
    ex[5] = 8'h53;
    for (int i = 6; i < 16; i++) ex[i] = 8'h00;
    {ex[1], ex[0]} = calc_crc(len);
    stall <= poke;
    load_page();
    kick(poke);
    check("page_len", page_len, 16'(len));
    check("err flags", {14'h0000, table_err, size_err}, 16'h0000);
    k = 0;
    while (rx_cnt < 8'(len) && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (20) @(posedge clk);
    #1;
    check("byte count", {8'h00, rx_cnt}, 16'(len));
    check("busy", {15'h0000, busy}, 16'h0000);
    for (int i = 0; i < len; i++) begin
      check($sformatf("byte %0d", i), {8'h00, epg_host_sink_i.mem[i]}, {8'h00, ex[i]});
    end
    check("crc_o", crc, {ex[1], ex[0]});
    check("sig_ok", {15'h0000, sig_ok}, 16'h0001);
    $display("test %s done", name);
  endtask : run_page

  // full: every main slot present, so a type 1 in slot 0 forces the extra pair walk
  task automatic run_err(input logic [31:0] tbl, input logic [1:0] flags, input bit full);
    fill(tbl[31:24], tbl[23:16], tbl[15:8], tbl[7:0]);
    if (full) begin
      for (int i = 20; i < 32; i++) pg[i] = 8'h01;
    end
    load_page();
    kick(1'b0);
    check("err flags", {14'h0000, table_err, size_err}, {14'h0000, flags});
    repeat (30) @(posedge clk);
    #1;
    check("bytes on error", {8'h00, rx_cnt}, 16'h0000);
    $display("test error table %h done", tbl);
  endtask : run_err

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // list ends at slot 1, slot 2 must read zero
    fill(8'h02, 8'h01, 8'h00, 8'h00);
    pg[20] = 8'h02;
    pg[21] = 8'h01;
    run_page("basic", 48, 1, 1'b0);
    fill(8'h00, 8'h00, 8'h02, 8'h01);
    run_page("empty", 32, 0, 1'b0);
    fill(8'h01, 8'h01, 8'h02, 8'h01);
    for (int i = 32; i < 48; i++) pg[i] = 8'h00;
    run_page("ext list", 64, 2, 1'b1);
    for (int i = 0; i < 5; i++) run_err(bad[i], 2'b10, 1'b0);
    run_err(32'h0203_0000, 2'b01, 1'b0);
    run_err(32'h0101_0201, 2'b11, 1'b1);
    print_verdict();
  end

  initial begin
    #100us;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : tb_top
